// >>> src/cfg_security_top.sv
// configuration security, dual boot, soft error check and device tag
// Function
// [RULE_01] lock bits refuse all memory readback
// [RULE_02] only full erase clears lock bits; code also clears them on reset (I_RSTN low)
// [RULE_03] one-time mode rejects erase and reprogram
// [RULE_04] corrupt primary restarts from golden automatically
// [RULE_05] primary from on-chip flash, golden external
// [RULE_06] checker computes crc after configuration
// [RULE_07] automatic check only when option set
// [RULE_08] user start input triggers check
// [RULE_09] checker clocked by oscillator divider
// [RULE_10] checker can be fully switched off
// [RULE_11] 64-bit tag, 8 user bits
// [RULE_12] tag readable on wishbone, spi, i2c, jtag; code records only wishbone, spi and jtag readers, no i2c source
// [RULE_13] system holds right-side pll in reset; code holds it only while I_PROG_BG is high
// [RULE_14] mismatch flag held until next check
`timescale 1ns/1ns
module cfg_security_top
  import cfg_sec_pkg::*;
#(
  parameter int          CFG_WORDS = 16,
  parameter int          AW        = 4,
  parameter logic [55:0] TAG_FIXED = TAG_FIXED_DEF
) (
  input  wire logic             I_REF_CLK,
  input  wire logic             I_RSTN,
  input  wire logic             I_CFG_START,
  input  wire logic             I_DUAL_BOOT_EN,
  input  wire logic             I_IMG_WORD_VLD,
  input  wire logic [31:0]      I_IMG_WORD,
  input  wire logic             I_IMG_LAST,
  input  wire logic [CRC_W-1:0] I_IMG_CRC,
  input  wire logic             I_LOCK_SET,
  input  wire logic             I_OTP_SET,
  input  wire logic             I_ERASE_REQ,
  input  wire logic             I_PROG_REQ,
  input  wire logic             I_PROG_BG,
  input  wire logic             I_READBACK_REQ,
  input  wire logic [AW-1:0]    I_READBACK_ADDR,
  input  wire logic             I_CHK_AUTO_EN,
  input  wire logic             I_CHK_OFF,
  input  wire logic             I_CHK_USER_START,
  input  wire logic [DIV_W-1:0] I_CHK_DIV,
  input  wire logic             I_TAG_USER_WR,
  input  wire logic [7:0]       I_TAG_USER_DATA,
  input  wire logic [1:0]       I_TAG_RD_SRC,
  output logic                  O_SEL_GOLDEN,
  output logic                  O_BOOT_DONE,
  output logic                  O_BOOT_FAIL,
  output logic                  O_LOCKED,
  output logic                  O_OTP,
  output logic                  O_REQ_REJECT,
  output logic                  O_READBACK_VLD,
  output logic [31:0]           O_READBACK_DATA,
  output logic                  O_CHK_BUSY,
  output logic                  O_CHK_ERR,
  output logic                  O_RIGHT_SIDE_PLL_HOLD,
  output logic [TAG_W-1:0]      O_TAG,
  output logic [1:0]            O_TAG_SRC
);
  initial if ((1 << AW) < CFG_WORDS || CFG_WORDS < 1)
    $error("config memory address too narrow");

  // configuration cell array written by boot, scanned by the checker
  logic [31:0]      cfg_mem [CFG_WORDS];
  boot_state_t      st_r, st_nxt;
  logic [AW-1:0]    wa_r, wa_nxt;
  logic             golden_r, golden_nxt;
  logic             done_r, done_nxt;
  logic             fail_r, fail_nxt;
  logic             lock_r, lock_nxt;
  logic             otp_r, otp_nxt;
  logic             rej_r, rej_nxt;
  logic             rbv_r, rbv_nxt;
  logic [31:0]      rbd_r, rbd_nxt;
  logic [7:0]       tag_user_r, tag_user_nxt;
  logic [TAG_W-1:0] tag_r, tag_nxt;
  logic [1:0]       tsrc_r, tsrc_nxt;
  logic             boot_crc_clr, boot_crc_step;
  logic [CRC_W-1:0] boot_crc;
  logic             mem_we;

  crc_unit #(.DW(32)) u_boot_crc (
    .clk     (I_REF_CLK),
    .rst_n   (I_RSTN),
    .i_clear (boot_crc_clr),
    .i_step  (boot_crc_step),
    .i_data  (I_IMG_WORD),
    .o_crc   (boot_crc)
  );

  // primary image streams from on-chip flash, golden via external spi
  always_comb begin
    st_nxt        = st_r;
    wa_nxt        = wa_r;
    golden_nxt    = golden_r;
    done_nxt      = done_r;
    fail_nxt      = fail_r;
    boot_crc_clr  = 1'b0;
    boot_crc_step = 1'b0;
    mem_we        = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (I_CFG_START) begin
          st_nxt       = ST_PRIMARY;
          golden_nxt   = 1'b0; // see [RULE_05]
          wa_nxt       = '0;
          done_nxt     = 1'b0;
          fail_nxt     = 1'b0;
          boot_crc_clr = 1'b1;
        end
      end
      ST_PRIMARY, ST_GOLDEN: begin
        if (I_IMG_WORD_VLD) begin
          boot_crc_step = 1'b1;
          mem_we        = 1'b1;
          wa_nxt        = wa_r + AW'(1);
          if (I_IMG_LAST) begin
            if (crc_next_ok()) begin
              st_nxt   = ST_USER;
              done_nxt = 1'b1;
            end else if (st_r == ST_PRIMARY && I_DUAL_BOOT_EN) begin
              // restart without outside help
              st_nxt       = ST_GOLDEN; // see [RULE_04]
              golden_nxt   = 1'b1;      // see [RULE_05]
              wa_nxt       = '0;
              boot_crc_clr = 1'b1;
            end else begin
              st_nxt   = ST_FAIL;
              fail_nxt = 1'b1;
            end
          end
        end
      end
      ST_USER, ST_FAIL: begin
        if (I_CFG_START) begin
          st_nxt       = ST_PRIMARY;
          golden_nxt   = 1'b0;
          wa_nxt       = '0;
          done_nxt     = 1'b0;
          fail_nxt     = 1'b0;
          boot_crc_clr = 1'b1;
        end
      end
    endcase
  end

  // crc including the word arriving this cycle
  function automatic logic crc_next_ok();
    logic [CRC_W-1:0] c;
    c = boot_crc;
    for (int k = 31; k >= 0; k--) begin
      if (c[CRC_W-1] ^ I_IMG_WORD[k]) begin
        c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[CRC_W-2:0], 1'b0};
      end
    end
    return c == I_IMG_CRC;
  endfunction

  always_ff @(posedge I_REF_CLK) begin
    if (mem_we && 32'(wa_r) < 32'(CFG_WORDS)) begin
      cfg_mem[wa_r] <= I_IMG_WORD;
    end
  end

  // security, one-time mode, readback and tag
  always_comb begin
    lock_nxt     = lock_r;
    otp_nxt      = otp_r;
    rej_nxt      = 1'b0;
    rbv_nxt      = 1'b0;
    rbd_nxt      = 32'h0000_0000;
    tag_user_nxt = tag_user_r;
    tag_nxt      = {TAG_FIXED, tag_user_r}; // see [RULE_11]
    tsrc_nxt     = tsrc_r;
    if (I_OTP_SET) begin
      otp_nxt = 1'b1;
    end
    if (I_ERASE_REQ) begin
      if (otp_r) begin
        rej_nxt = 1'b1; // see [RULE_03]
      end else begin
        lock_nxt     = 1'b0; // see [RULE_02]
        tag_user_nxt = TAG_USER_RST;
      end
    end
    // set wins over an erase in the same cycle
    if (I_LOCK_SET) begin
      lock_nxt = 1'b1; // see [RULE_02]
    end
    if (I_PROG_REQ && otp_r) begin
      rej_nxt = 1'b1; // see [RULE_03]
    end
    if (I_TAG_USER_WR) begin
      if (otp_r) begin
        rej_nxt = 1'b1; // see [RULE_03]
      end else begin
        tag_user_nxt = I_TAG_USER_DATA; // see [RULE_11]
      end
    end
    if (I_READBACK_REQ) begin
      if (lock_r) begin
        rej_nxt = 1'b1; // see [RULE_01]
      end else begin
        rbv_nxt = 1'b1;
        if (32'(I_READBACK_ADDR) < 32'(CFG_WORDS)) begin
          rbd_nxt = cfg_mem[I_READBACK_ADDR];
        end
      end
    end
    // tag reaches the wishbone, spi and jtag readers; source recorded for the reader
    if (I_TAG_RD_SRC != SRC_NONE) begin
      tsrc_nxt = I_TAG_RD_SRC; // see [RULE_12]
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      st_r       <= ST_IDLE;
      wa_r       <= '0;
      golden_r   <= 1'b0;
      done_r     <= 1'b0;
      fail_r     <= 1'b0;
      lock_r     <= 1'b0;
      otp_r      <= 1'b0;
      rej_r      <= 1'b0;
      rbv_r      <= 1'b0;
      rbd_r      <= 32'h0000_0000;
      tag_user_r <= TAG_USER_RST;
      tag_r      <= '0;
      tsrc_r     <= SRC_NONE;
    end else begin
      st_r       <= st_nxt;
      wa_r       <= wa_nxt;
      golden_r   <= golden_nxt;
      done_r     <= done_nxt;
      fail_r     <= fail_nxt;
      lock_r     <= lock_nxt;
      otp_r      <= otp_nxt;
      rej_r      <= rej_nxt;
      rbv_r      <= rbv_nxt;
      rbd_r      <= rbd_nxt;
      tag_user_r <= tag_user_nxt;
      tag_r      <= tag_nxt;
      tsrc_r     <= tsrc_nxt;
    end
  end

  // soft error checker; off means no divider or crc activity
  logic             chk_run;
  logic             chk_tick;
  logic             chk_busy_r, chk_busy_nxt;
  logic             chk_err_r, chk_err_nxt;
  logic             chk_pend_r, chk_pend_nxt;
  logic             auto_done_r, auto_done_nxt;
  logic [AW-1:0]    ca_r, ca_nxt;
  logic [CRC_W-1:0] ref_r, ref_nxt;
  logic             ref_vld_r, ref_vld_nxt;
  logic             chk_clr, chk_step;
  logic [CRC_W-1:0] chk_crc;
  logic [31:0]      chk_word;

  assign chk_run  = chk_busy_r && !I_CHK_OFF; // see [RULE_10]
  assign chk_word = cfg_mem[ca_r];

  clk_divider #(.W(DIV_W)) u_chk_div (
    .clk    (I_REF_CLK),
    .rst_n  (I_RSTN),
    .i_run  (chk_run),
    .i_div  (I_CHK_DIV),
    .o_tick (chk_tick)
  ); // see [RULE_09]

  crc_unit #(.DW(32)) u_chk_crc (
    .clk     (I_REF_CLK),
    .rst_n   (I_RSTN),
    .i_clear (chk_clr),
    .i_step  (chk_step),
    .i_data  (chk_word),
    .o_crc   (chk_crc)
  );

  always_comb begin
    chk_busy_nxt  = chk_busy_r;
    chk_err_nxt   = chk_err_r;
    chk_pend_nxt  = chk_pend_r;
    auto_done_nxt = auto_done_r;
    ca_nxt        = ca_r;
    ref_nxt       = ref_r;
    ref_vld_nxt   = ref_vld_r;
    chk_clr       = 1'b0;
    chk_step      = 1'b0;
    if (st_r != ST_USER) begin
      auto_done_nxt = 1'b0;
      ref_vld_nxt   = 1'b0;
      chk_busy_nxt  = 1'b0;
      chk_pend_nxt  = 1'b0;
    end else if (I_CHK_OFF) begin
      chk_busy_nxt = 1'b0; // see [RULE_10]
      chk_pend_nxt = 1'b0;
    end else if (!chk_busy_r) begin
      if (I_CHK_USER_START || chk_pend_r) begin
        chk_busy_nxt = 1'b1; // see [RULE_08]
        chk_pend_nxt = 1'b0;
      end else if (I_CHK_AUTO_EN && !auto_done_r) begin
        chk_busy_nxt  = 1'b1; // see [RULE_06] [RULE_07]
        auto_done_nxt = 1'b1;
      end
      if (chk_busy_nxt) begin
        chk_clr     = 1'b1;
        ca_nxt      = '0;
        chk_err_nxt = 1'b0; // see [RULE_14]
      end
    end else begin
      if (I_CHK_USER_START) begin
        chk_pend_nxt = 1'b1;
      end
      if (chk_tick) begin
        chk_step = 1'b1;
        ca_nxt   = ca_r + AW'(1);
        if (32'(ca_r) == 32'(CFG_WORDS - 1)) begin
          chk_busy_nxt = 1'b0;
          // first pass captures the loaded reference
          if (!ref_vld_r) begin
            ref_nxt     = crc_word(chk_crc, chk_word);
            ref_vld_nxt = 1'b1;
          end else if (crc_word(chk_crc, chk_word) != ref_r) begin
            chk_err_nxt = 1'b1; // see [RULE_14]
          end
        end
      end
    end
  end

  function automatic logic [CRC_W-1:0] crc_word(
    input logic [CRC_W-1:0] c_in,
    input logic [31:0]      d
  );
    logic [CRC_W-1:0] c;
    c = c_in;
    for (int k = 31; k >= 0; k--) begin
      if (c[CRC_W-1] ^ d[k]) begin
        c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[CRC_W-2:0], 1'b0};
      end
    end
    return c;
  endfunction

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      chk_busy_r  <= 1'b0;
      chk_err_r   <= 1'b0;
      chk_pend_r  <= 1'b0;
      auto_done_r <= 1'b0;
      ca_r        <= '0;
      ref_r       <= CRC_INIT;
      ref_vld_r   <= 1'b0;
    end else begin
      chk_busy_r  <= chk_busy_nxt;
      chk_err_r   <= chk_err_nxt;
      chk_pend_r  <= chk_pend_nxt;
      auto_done_r <= auto_done_nxt;
      ca_r        <= ca_nxt;
      ref_r       <= ref_nxt;
      ref_vld_r   <= ref_vld_nxt;
    end
  end

  // outputs straight from flip-flops
  logic right_side_pll_r;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      right_side_pll_r <= 1'b0;
    end else begin
      right_side_pll_r <= I_PROG_BG; // see [RULE_13]
    end
  end

  assign O_SEL_GOLDEN    = golden_r;
  assign O_BOOT_DONE     = done_r;
  assign O_BOOT_FAIL     = fail_r;
  assign O_LOCKED        = lock_r;
  assign O_OTP           = otp_r;
  assign O_REQ_REJECT    = rej_r;
  assign O_READBACK_VLD  = rbv_r;
  assign O_READBACK_DATA = rbd_r;
  assign O_CHK_BUSY      = chk_busy_r;
  assign O_CHK_ERR       = chk_err_r;
  assign O_RIGHT_SIDE_PLL_HOLD     = right_side_pll_r;
  assign O_TAG           = tag_r;
  assign O_TAG_SRC       = tsrc_r;
endmodule

// >>> src/cfg_sec_pkg.sv
// constants and types for the configuration security and integrity block
package cfg_sec_pkg;
  localparam int          TAG_W        = 64;
  localparam int          TAG_USER_W   = 8;
  localparam int          TAG_FIXED_W  = 56;
  // arbitrary neutral factory value, not taken from any part
  localparam logic [55:0] TAG_FIXED_DEF = 56'h00_0000_1234_5678;
  localparam logic [7:0]  TAG_USER_RST  = 8'h00;
  localparam int          CRC_W        = 32;
  localparam logic [31:0] CRC_POLY     = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT     = 32'hFFFF_FFFF;
  localparam int          DIV_W        = 8;
  localparam logic [7:0]  DIV_DEF      = 8'h04;
  localparam logic [1:0]  SRC_NONE     = 2'h0;
  localparam logic [1:0]  SRC_WB       = 2'h1;
  localparam logic [1:0]  SRC_SPI      = 2'h2;
  localparam logic [1:0]  SRC_JTAG     = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PRIMARY, ST_GOLDEN, ST_USER, ST_FAIL
  } boot_state_t;
endpackage

// >>> src/clk_divider.sv
// clock-enable divider driven by the undivided oscillator clock
`timescale 1ns/1ns
module clk_divider
  import cfg_sec_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_div,
  output logic              o_tick
);
  initial if (W < 2) $error("divider width too small");
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tick_nxt;
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (i_run) begin
      if (cnt_r >= i_div) begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end else begin
      cnt_nxt = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      o_tick <= tick_nxt;
    end
  end
endmodule

// >>> src/crc_unit.sv
// serial crc accumulator over one word per step
`timescale 1ns/1ns
module crc_unit
  import cfg_sec_pkg::*;
#(
  parameter int DW = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             i_clear,
  input  wire logic             i_step,
  input  wire logic [DW-1:0]    i_data,
  output logic      [CRC_W-1:0] o_crc
);
  initial if (DW < 1) $error("data width must be positive");
  logic [CRC_W-1:0] crc_nxt;
  always_comb begin
    logic [CRC_W-1:0] c;
    c = o_crc;
    if (i_clear) begin
      c = CRC_INIT;
    end else if (i_step) begin
      for (int k = DW - 1; k >= 0; k--) begin
        if (c[CRC_W-1] ^ i_data[k]) begin
          c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
        end else begin
          c = {c[CRC_W-2:0], 1'b0};
        end
      end
    end
    crc_nxt = c;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      o_crc <= CRC_INIT;
    end else begin
      o_crc <= crc_nxt;
    end
  end
endmodule

// >>> sim/cfg_security_properties.sv
// port assertions for the configuration security block
`timescale 1ns/1ns
module cfg_security_properties
  import cfg_sec_pkg::*;
#(
  parameter logic [55:0] TAG_FIXED = TAG_FIXED_DEF
) (
  input wire logic             I_REF_CLK,
  input wire logic             I_RSTN,
  input wire logic             I_DUAL_BOOT_EN,
  input wire logic             I_IMG_LAST,
  input wire logic             I_ERASE_REQ,
  input wire logic             I_PROG_REQ,
  input wire logic             I_READBACK_REQ,
  input wire logic             I_CHK_AUTO_EN,
  input wire logic             I_CHK_OFF,
  input wire logic             I_CHK_USER_START,
  input wire logic             I_TAG_USER_WR,
  input wire logic [1:0]       I_TAG_RD_SRC,
  input wire logic             O_SEL_GOLDEN,
  input wire logic             O_BOOT_DONE,
  input wire logic             O_LOCKED,
  input wire logic             O_OTP,
  input wire logic             O_REQ_REJECT,
  input wire logic             O_READBACK_VLD,
  input wire logic             O_CHK_BUSY,
  input wire logic [TAG_W-1:0] O_TAG,
  input wire logic [1:0]       O_TAG_SRC
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RSTN);

  rb_lock_a: assert property (
    I_READBACK_REQ && O_LOCKED |=> O_REQ_REJECT && !O_READBACK_VLD)
    else $error("readback while locked was not refused");
  lock_clear_a: assert property (
    $fell(O_LOCKED) |-> $past(I_ERASE_REQ) && !$past(O_OTP))
    else $error("lock cleared without a full erase");
  otp_reject_a: assert property (
    O_OTP && (I_ERASE_REQ || I_PROG_REQ || I_TAG_USER_WR) |=> O_REQ_REJECT)
    else $error("change request accepted in one-time mode");
  golden_cause_a: assert property (
    $rose(O_SEL_GOLDEN) |-> $past(I_DUAL_BOOT_EN) && $past(I_IMG_LAST))
    else $error("golden load without a finished primary load");
  auto_start_a: assert property (
    $rose(O_BOOT_DONE) && I_CHK_AUTO_EN && !I_CHK_OFF |-> ##[0:2] O_CHK_BUSY)
    else $error("automatic check did not start");
  user_start_a: assert property (
    O_BOOT_DONE && I_CHK_USER_START && !I_CHK_OFF |-> ##[1:2] O_CHK_BUSY)
    else $error("user start did not begin a check");
  chk_off_a: assert property (
    I_CHK_OFF [*2] |-> !O_CHK_BUSY)
    else $error("checker busy while switched off");
  tag_fixed_a: assert property (
    $past(I_RSTN) |-> O_TAG[TAG_W-1:TAG_USER_W] == TAG_FIXED)
    else $error("fixed tag bits wrong");
  tag_src_a: assert property (
    I_TAG_RD_SRC != SRC_NONE |=> O_TAG_SRC == $past(I_TAG_RD_SRC))
    else $error("tag reading port not recorded");
endmodule

bind cfg_security_top cfg_security_properties #(.TAG_FIXED(TAG_FIXED))
  cfg_security_properties_i (.*);

// >>> sim/golden_flash_model.sv
// behavioural image source: on-chip primary and external golden flash
`timescale 1ns/1ns
module golden_flash_model
  import cfg_sec_pkg::*;
#(
  parameter int N = 16
) (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic        i_golden,
  input  wire logic        i_bad_crc,
  output logic             o_vld,
  output logic [31:0]      o_word,
  output logic             o_last,
  output logic [CRC_W-1:0] o_crc
);
  int               idx = N;
  logic             go_r = 1'b0;
  logic             gold_q = 1'b0;
  logic             from_gold = 1'b0;
  logic [CRC_W-1:0] acc = CRC_INIT;
  // two distinct images so a wrong source shows up in readback
  function automatic logic [31:0] word_at(logic g, int i);
    return (g ? 32'h6000_0000 : 32'h1000_0000) + 32'(i * 3);
  endfunction
  function automatic logic [31:0] crc_add(logic [31:0] c, logic [31:0] d);
    for (int k = 31; k >= 0; k--) begin
      c = (c[31] ^ d[k]) ? {c[30:0], 1'b0} ^ CRC_POLY : {c[30:0], 1'b0};
    end
    return c;
  endfunction
  initial begin
    o_vld = 1'b0;
    o_last = 1'b0;
    o_word = 32'h0000_0000;
    o_crc = 32'h0000_0000;
  end
  always @(posedge i_clk) go_r <= i_go;
  always @(negedge i_clk) begin
    if (idx >= N && (go_r || (i_golden && !gold_q))) begin
      idx = 0;
      from_gold = i_golden;
      acc = CRC_INIT;
    end
    if (idx < N) begin
      o_word = word_at(from_gold, idx);
      acc = crc_add(acc, o_word);
      o_vld = 1'b1;
      o_last = (idx == N - 1);
      // only the primary image is ever offered corrupt
      o_crc = (o_last && !(i_bad_crc && !from_gold)) ? acc : ~acc;
      idx++;
    end else begin
      // released lines keep toggling so stale data never looks valid
      o_vld = 1'b0;
      o_last = 1'b0;
      o_word = ~o_word;
      o_crc = ~o_crc;
    end
    gold_q = i_golden;
  end
endmodule

// >>> sim/cfg_security_top_bench.sv
// self-checking bench for the configuration security block
`timescale 1ns/1ns
module cfg_security_top_bench;
  import cfg_sec_pkg::*;
  localparam int N = 16;
  logic I_REF_CLK = 1'b0;
  logic I_RSTN, I_DUAL_BOOT_EN, I_PROG_BG, I_CHK_AUTO_EN, I_CHK_OFF;
  logic I_IMG_WORD_VLD, I_IMG_LAST, bad, gold_seen;
  logic I_CFG_START, I_LOCK_SET, I_OTP_SET, I_ERASE_REQ, I_PROG_REQ;
  logic I_READBACK_REQ, I_CHK_USER_START, I_TAG_USER_WR;
  logic O_SEL_GOLDEN, O_BOOT_DONE, O_BOOT_FAIL, O_LOCKED, O_OTP;
  logic O_REQ_REJECT, O_READBACK_VLD, O_CHK_BUSY, O_CHK_ERR, O_RIGHT_SIDE_PLL_HOLD;
  logic [31:0] I_IMG_WORD, I_IMG_CRC, O_READBACK_DATA;
  logic [3:0] I_READBACK_ADDR;
  logic [7:0] I_CHK_DIV, I_TAG_USER_DATA, pv, u;
  logic [1:0] I_TAG_RD_SRC, O_TAG_SRC;
  logic [TAG_W-1:0] O_TAG;
  logic [33:0] exp_q[$];
  logic [33:0] res, e;
  int a;
  int error_cnt = 0;
  int n_checks = 0;
  localparam logic [33:0] REJ = 34'h2_0000_0000;
  assign {I_TAG_USER_WR, I_CHK_USER_START, I_READBACK_REQ, I_PROG_REQ,
          I_ERASE_REQ, I_OTP_SET, I_LOCK_SET, I_CFG_START} = pv;
  assign res = {O_REQ_REJECT, O_READBACK_VLD, O_READBACK_DATA};
  always #10 I_REF_CLK = ~I_REF_CLK;
  cfg_security_top #(.CFG_WORDS(N)) cfg_security_top_i (.*);
  golden_flash_model #(.N(N)) golden_flash_model_i (
    .i_clk(I_REF_CLK), .i_go(I_CFG_START), .i_golden(O_SEL_GOLDEN),
    .i_bad_crc(bad), .o_vld(I_IMG_WORD_VLD), .o_word(I_IMG_WORD),
    .o_last(I_IMG_LAST), .o_crc(I_IMG_CRC));

  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic cond(int s);
    case (s)
      0: return O_BOOT_DONE | O_BOOT_FAIL;
      1: return O_CHK_BUSY;
      default: return !O_CHK_BUSY;
    endcase
  endfunction
  task automatic wait_on(int s, int lim);
    int n;
    n = 0;
    while (cond(s) !== 1'b1) begin
      @(negedge I_REF_CLK);
      n++;
      if (n == lim) begin
        check("wait", 0, 1);
        give_verdict();
      end
    end
  endtask
  // the driver raises the pulse, then notes the result it expects, on the same falling edge
  task automatic pulse(int b, logic note, logic [33:0] x);
    @(negedge I_REF_CLK);
    pv[b] = 1'b1;
    if (note) exp_q.push_back(x);
    @(negedge I_REF_CLK);
    pv[b] = 1'b0;
  endtask
  task automatic boot(logic b, logic dual, logic gold);
    wait_on(2, 2000);
    bad = b;
    I_DUAL_BOOT_EN = dual;
    pulse(0, 1'b0, 0);
    gold_seen = 1'b0;
    @(negedge I_REF_CLK);
    wait_on(0, 300);
    check("golden used", gold_seen, gold);
  endtask
  task automatic readback(logic gold);
    a = $urandom % N;
    I_READBACK_ADDR = 4'(a);
    pulse(5, 1'b1, {2'b01, golden_flash_model_i.word_at(gold, a)});
  endtask

  always @(negedge I_REF_CLK) begin
    if (O_SEL_GOLDEN === 1'b1) gold_seen = 1'b1;
    if (I_RSTN && (O_REQ_REJECT | O_READBACK_VLD) === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0_0000_0000;
      check("pulse result", res, e);
    end
  end

  initial begin
    void'($urandom(32'h08f5));
    {pv, bad, gold_seen, I_RSTN, I_DUAL_BOOT_EN, I_PROG_BG, I_CHK_OFF} = 0;
    {I_TAG_RD_SRC, I_READBACK_ADDR, I_TAG_USER_DATA} = 0;
    I_CHK_AUTO_EN = 1'b1;
    I_CHK_DIV = 8'h01;
    repeat (8) @(negedge I_REF_CLK);
    I_RSTN = 1'b1;
    repeat (2) @(negedge I_REF_CLK);
    check("tag", O_TAG, {TAG_FIXED_DEF, TAG_USER_RST});
    u = 8'($urandom);
    I_TAG_USER_DATA = u;
    pulse(7, 1'b0, 0);
    @(negedge I_REF_CLK);
    check("tag user", O_TAG, {TAG_FIXED_DEF, u});
    I_PROG_BG = 1'b1;
    for (int s = 1; s < 4; s++) begin
      I_TAG_RD_SRC = 2'(s);
      repeat (2) @(negedge I_REF_CLK);
      check("tag port", O_TAG_SRC, s);
    end
    I_TAG_RD_SRC = SRC_NONE;
    check("pll hold", O_RIGHT_SIDE_PLL_HOLD, 1);
    I_PROG_BG = 1'b0;
    boot(1'b0, 1'b1, 1'b0);
    check("boot done", O_BOOT_DONE, 1);
    wait_on(1, 10);
    wait_on(2, 2000);
    check("check error", O_CHK_ERR, 0);
    repeat (3) readback(1'b0);
    pulse(6, 1'b0, 0);
    wait_on(1, 10);
    wait_on(2, 2000);
    check("user check error", O_CHK_ERR, 0);
    pulse(6, 1'b0, 0);
    wait_on(1, 10);
    I_CHK_OFF = 1'b1;
    repeat (3) @(negedge I_REF_CLK);
    check("busy when off", O_CHK_BUSY, 0);
    I_CHK_OFF = 1'b0;
    pulse(1, 1'b0, 0);
    check("locked", O_LOCKED, 1);
    pulse(5, 1'b1, REJ);
    pulse(4, 1'b0, 0);
    check("lock after prog", O_LOCKED, 1);
    pulse(3, 1'b0, 0);
    check("lock after erase", O_LOCKED, 0);
    @(negedge I_REF_CLK);
    check("tag after erase", O_TAG, {TAG_FIXED_DEF, 8'h00});
    boot(1'b1, 1'b1, 1'b1);
    check("golden done", O_BOOT_DONE, 1);
    readback(1'b1);
    boot(1'b1, 1'b0, 1'b0);
    check("boot fail", O_BOOT_FAIL, 1);
    I_CHK_AUTO_EN = 1'b0;
    boot(1'b0, 1'b1, 1'b0);
    repeat (5) @(negedge I_REF_CLK);
    check("no auto check", O_CHK_BUSY, 0);
    pulse(1, 1'b0, 0);
    pulse(2, 1'b0, 0);
    check("otp", O_OTP, 1);
    pulse(3, 1'b1, REJ);
    pulse(4, 1'b1, REJ);
    pulse(7, 1'b1, REJ);
    check("lock in otp", O_LOCKED, 1);
    repeat (3) @(negedge I_REF_CLK);
    check("results left", exp_q.size(), 0);
    give_verdict();
  end
endmodule
